// ===== common/hbrpc_pkg.sv
`default_nettype none
package hbrpc_pkg;

  // ==========================================================
  // Clock and reset timing
  // ==========================================================
  localparam int CLK_FREQ_HZ            = 25_000_000;
  localparam int POWER_RESET_MIN_MS     = 2;
  // Least time, so round up to whole cycles
  localparam int POWER_RESET_MIN_CYCLES = (POWER_RESET_MIN_MS * CLK_FREQ_HZ + 999) / 1000;
  localparam int RST_CNT_WIDTH          = 16;

  // ==========================================================
  // Bus and register widths, reset values
  // ==========================================================
  localparam int AD_WIDTH  = 32;
  localparam int CBE_WIDTH = 4;
  localparam int CFG_WIDTH = 16;
  localparam int CTX_WIDTH = 8;
  localparam logic [CFG_WIDTH-1:0] CFG_RESET   = 16'h0000;
  localparam logic [CTX_WIDTH-1:0] CTX_RESET   = 8'h00;
  // Strap default before the first capture: plain host bus mode
  localparam logic                 STRAP_RESET = 1'h1;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    HBRPC_POWER_RST,
    HBRPC_BUS_RST,
    HBRPC_ACTIVE
  } hbrpc_mode_e;

  typedef struct packed {
    logic                 valid;
    logic [AD_WIDTH-1:0]  ad;
    logic [CBE_WIDTH-1:0] cbe;
  } hbrpc_phase_s;

  typedef struct packed {
    logic [AD_WIDTH-1:0]  ad;
    logic                 ad_oe;
    logic [CBE_WIDTH-1:0] cbe;
    logic                 cbe_oe;
    logic                 par;
    logic                 par_oe;
    logic                 irq;
    logic                 irq_oe;
  } hbrpc_bus_out_s;

  typedef struct packed {
    hbrpc_mode_e              mode;
    logic                     pwr_s1;
    logic                     pwr_s2;
    logic                     bus_s1;
    logic                     bus_s2;
    logic                     strap_s1;
    logic                     strap_s2;
    logic                     strap;
    logic [RST_CNT_WIDTH-1:0] cnt;
    logic                     short_rst;
    logic [CFG_WIDTH-1:0]     cfg;
    logic [CTX_WIDTH-1:0]     ctx;
    hbrpc_bus_out_s           out;
    logic                     tgt_check;
    logic [AD_WIDTH-1:0]      tgt_ad;
    logic [CBE_WIDTH-1:0]     tgt_cbe;
    logic                     perr;
  } hbrpc_state_s;

endpackage
`default_nettype wire

// ===== hdl/hbrpc_top.sv
// How it works
// - A global power reset returns every register but the short-reset flag and the width counter, which counts, the context bits included, to its default.
// - During a global power reset the block is idle and every output enable is low.
// - During a host bus reset the block is idle and every output enable is low.
// - A host bus reset clears the ordinary registers but keeps the context bits.
// - All bus signals are sampled on the rising edge of the host bus clock.
// - Interrupts leave on the interrupt pin, in card-slot form when the strap is low.
// - The shared lines carry a 32-bit address in the address phase and data in data phases.
// - The four command lines carry the command, then per-byte enables.
// - Even parity over address/data and command lines is driven one clock after its phase.
`timescale 1ns/1ps
`default_nettype none
module hbrpc_top
  import hbrpc_pkg::*;
#(
  parameter int POWER_RESET_CYCLES = POWER_RESET_MIN_CYCLES
) (
  input  wire logic                     clk_sys_i,           // Host bus clock
  input  wire logic                     reset_i,             // Synchronous system reset
  input  wire logic                     power_reset_n_i,     // Global power reset pin
  input  wire logic                     host_bus_reset_n_i,  // Host bus reset pin
  input  wire logic                     card_slot_mode_strap_i, // Low selects card-slot mode
  input  wire hbrpc_pkg::hbrpc_phase_s  init_phase_i,        // Phase to drive as initiator
  input  wire logic                     tgt_phase_i,         // Bus phase to check as target
  input  wire logic [AD_WIDTH-1:0]      ad_i,                // Address/data lines in
  input  wire logic [CBE_WIDTH-1:0]     cmd_byte_enable_bus_i, // Command/byte-enable lines in
  input  wire logic                     bus_parity_line_i,   // Parity line in
  input  wire logic                     irq_req_i,           // Internal interrupt request
  input  wire logic                     cfg_wr_i,            // Write ordinary register
  input  wire logic [CFG_WIDTH-1:0]     cfg_wdata_i,         // Ordinary register data
  input  wire logic                     ctx_wr_i,            // Write context register
  input  wire logic [CTX_WIDTH-1:0]     ctx_wdata_i,         // Context register data
  output var  hbrpc_pkg::hbrpc_bus_out_s bus_o,              // Pin drive and enables
  output logic [CFG_WIDTH-1:0]          cfg_o,               // Ordinary register
  output logic [CTX_WIDTH-1:0]          ctx_o,               // Context register
  output logic                          active_o,            // Block out of reset
  output logic                          card_slot_mode_o,    // Captured strap, high in card mode
  output logic                          power_reset_short_o, // Power reset was too short
  output logic                          parity_err_o         // Target parity miscompare pulse
);
  import hbrpc_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  localparam hbrpc_bus_out_s BUS_IDLE = '0;

  hbrpc_state_s state_reg;
  hbrpc_state_s state_next;

  // ==========================================================
  // Helpers
  // ==========================================================

  function automatic logic even_parity(input logic [AD_WIDTH-1:0] ad, input logic [CBE_WIDTH-1:0] cbe);
    even_parity = ^{ad, cbe};
  endfunction

  // Held shorter than the least width
  function automatic logic reset_too_short(input logic [RST_CNT_WIDTH-1:0] cnt);
    reset_too_short = 32'(cnt) < 32'(POWER_RESET_CYCLES);
  endfunction

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    state_next = state_reg;
    // Pins are asynchronous; two flops before use
    // A reset pulse shorter than one clock may pass unseen
    // reset release synchronised
    state_next.pwr_s1   = power_reset_n_i;
    state_next.pwr_s2   = state_reg.pwr_s1;
    state_next.bus_s1   = host_bus_reset_n_i;
    state_next.bus_s2   = state_reg.bus_s1;
    state_next.strap_s1 = card_slot_mode_strap_i;
    state_next.strap_s2 = state_reg.strap_s1;
    state_next.perr     = 1'b0;
    state_next.tgt_check = 1'b0;

    if (!state_reg.pwr_s2)
    begin
      state_next.mode = HBRPC_POWER_RST;
      state_next.cfg  = CFG_RESET;
      state_next.ctx  = CTX_RESET;
      state_next.strap   = STRAP_RESET;
      state_next.tgt_ad  = '0;
      state_next.tgt_cbe = '0;
      // Short-reset flag kept: it reports this very reset
      // all drivers off
      state_next.out  = BUS_IDLE;
      if (state_reg.cnt != {RST_CNT_WIDTH{1'b1}})
      begin
        state_next.cnt = state_reg.cnt + 1'b1;
      end
    end
    else if (!state_reg.bus_s2)
    begin
      // Leaving power reset straight into bus reset still checks the width
      if (state_reg.mode == HBRPC_POWER_RST)
      begin
        state_next.short_rst = state_reg.short_rst | reset_too_short(state_reg.cnt);
        state_next.strap = state_reg.strap_s2;
      end
      state_next.cnt  = '0;
      state_next.mode = HBRPC_BUS_RST;
      state_next.cfg  = CFG_RESET;
      // Stale target capture must not be compared after release
      state_next.tgt_ad  = '0;
      state_next.tgt_cbe = '0;
      state_next.out  = BUS_IDLE;
    end
    else
    begin
      if (state_reg.mode == HBRPC_POWER_RST)
      begin
        state_next.short_rst = state_reg.short_rst | reset_too_short(state_reg.cnt);
        // Strap is caught once, as power reset ends
        state_next.strap = state_reg.strap_s2;
      end
      state_next.cnt  = '0;
      state_next.mode = HBRPC_ACTIVE;

      if (state_reg.mode == HBRPC_ACTIVE)
      begin
        if (cfg_wr_i)
        begin
          state_next.cfg = cfg_wdata_i;
        end
        if (ctx_wr_i)
        begin
          state_next.ctx = ctx_wdata_i;
        end

        // address or data on shared lines
        state_next.out.ad     = init_phase_i.valid ? init_phase_i.ad : '0;
        state_next.out.ad_oe  = init_phase_i.valid;
        state_next.out.cbe    = init_phase_i.valid ? init_phase_i.cbe : '0;
        state_next.out.cbe_oe = init_phase_i.valid;
        state_next.out.par    = state_reg.out.ad_oe ? even_parity(state_reg.out.ad, state_reg.out.cbe) : 1'b0;
        state_next.out.par_oe = state_reg.out.ad_oe;

        if (state_reg.strap)
        begin
          // Open-drain, active low: drive only while asserting
          state_next.out.irq    = 1'b0;
          state_next.out.irq_oe = irq_req_i;
        end
        else
        begin
          state_next.out.irq    = ~irq_req_i;
          state_next.out.irq_oe = 1'b1;
        end

        if (tgt_phase_i)
        begin
          state_next.tgt_ad    = ad_i;
          state_next.tgt_cbe   = cmd_byte_enable_bus_i;
          state_next.tgt_check = 1'b1;
        end
        if (state_reg.tgt_check)
        begin
          state_next.perr = even_parity(state_reg.tgt_ad, state_reg.tgt_cbe) != bus_parity_line_i;
        end
      end
      else
      begin
        // First active cycle after release: drivers still off
        state_next.out = BUS_IDLE;
      end
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      state_reg           <= '0;
      state_reg.mode      <= HBRPC_POWER_RST;
      state_reg.strap     <= STRAP_RESET;
      state_reg.strap_s1  <= STRAP_RESET;
      state_reg.strap_s2  <= STRAP_RESET;
      state_reg.cfg       <= CFG_RESET;
      state_reg.ctx       <= CTX_RESET;
      state_reg.out       <= BUS_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign bus_o               = state_reg.out;
  assign cfg_o               = state_reg.cfg;
  assign ctx_o               = state_reg.ctx;
  assign active_o            = state_reg.mode == HBRPC_ACTIVE;
  assign card_slot_mode_o    = ~state_reg.strap;
  assign power_reset_short_o = state_reg.short_rst;
  assign parity_err_o        = state_reg.perr;

endmodule
`default_nettype wire

// ===== verification/hbrpc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host bridge model
// ==========================================================
module hbrpc_host_model
  import hbrpc_pkg::*;
(
  input  wire logic                 clk_i,     // Bus clock
  input  wire logic                 pwr_rst_i, // Hold power reset
  input  wire logic                 bus_rst_i, // Hold bus reset
  input  wire logic                 go_i,      // Start target phase
  input  wire logic [AD_WIDTH-1:0]  ad_i,      // Phase lines
  input  wire logic [CBE_WIDTH-1:0] cbe_i,     // Phase command
  input  wire logic                 bad_i,     // Corrupt parity
  output logic                      pwr_n_o,   // Power reset pin
  output logic                      bus_n_o,   // Bus reset pin
  output logic                      tgt_o,     // Phase marker
  output logic [AD_WIDTH-1:0]       ad_o,      // Lines
  output logic [CBE_WIDTH-1:0]      cbe_o,     // Command lines
  output logic                      par_o      // Parity line
);
  // phase, then lines flip once released
  initial
  begin
    {pwr_n_o, bus_n_o, tgt_o, ad_o, cbe_o, par_o} = '0;
    forever
    begin
      @(posedge clk_i);
      pwr_n_o <= !pwr_rst_i;
      bus_n_o <= !bus_rst_i;
      tgt_o   <= go_i;
      ad_o    <= go_i ? ad_i : ~ad_o;
      cbe_o   <= go_i ? cbe_i : ~cbe_o;
      par_o   <= tgt_o ? ^{ad_o, cbe_o, bad_i} : ~par_o;
    end
  end
endmodule
`default_nettype wire

// ===== verification/hbrpc_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Pin behaviour checks
// ==========================================================
module hbrpc_properties
  import hbrpc_pkg::*;
(
  input wire logic                      clk_sys_i,          // Clock
  input wire logic                      reset_i,            // Reset
  input wire logic                      power_reset_n_i,    // Power pin
  input wire logic                      host_bus_reset_n_i, // Bus pin
  input wire hbrpc_pkg::hbrpc_phase_s   init_phase_i,       // Phase in
  input wire logic                      irq_req_i,          // Request
  input wire hbrpc_pkg::hbrpc_bus_out_s bus_o,              // Pins out
  input wire logic [CFG_WIDTH-1:0]      cfg_o,              // Ordinary
  input wire logic [CTX_WIDTH-1:0]      ctx_o,              // Context
  input wire logic                      active_o,           // Active
  input wire logic                      card_slot_mode_o    // Card mode
);
  wire logic any_oe = bus_o.ad_oe | bus_o.cbe_oe | bus_o.par_oe | bus_o.irq_oe;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  property p_pwr_hiz; !power_reset_n_i [*3] |=> !any_oe; endproperty
  a_pwr_hiz: assert property (p_pwr_hiz) else $error("drive in power reset");
  property p_pwr_clr; !power_reset_n_i [*3] |=> cfg_o == CFG_RESET && ctx_o == CTX_RESET; endproperty
  a_pwr_clr: assert property (p_pwr_clr) else $error("power reset kept state");
  property p_bus_hiz; !host_bus_reset_n_i [*3] |=> !any_oe && !active_o; endproperty
  a_bus_hiz: assert property (p_bus_hiz) else $error("drive in bus reset");
  property p_bus_keep; (!host_bus_reset_n_i && power_reset_n_i) [*3] |=> cfg_o == CFG_RESET && $stable(ctx_o);
  endproperty
  a_bus_keep: assert property (p_bus_keep) else $error("bus reset scope wrong");
  property p_init; active_o && init_phase_i.valid |=> bus_o.ad_oe && bus_o.cbe_oe
    && bus_o.ad == $past(init_phase_i.ad) && bus_o.cbe == $past(init_phase_i.cbe); endproperty
  a_init: assert property (p_init) else $error("phase not driven");
  property p_par; active_o && bus_o.ad_oe |=> bus_o.par_oe && bus_o.par == ^{$past(bus_o.ad), $past(bus_o.cbe)};
  endproperty
  a_par: assert property (p_par) else $error("parity wrong");
  property p_irq; active_o ##1 active_o |-> (card_slot_mode_o ? bus_o.irq_oe && bus_o.irq == !$past(irq_req_i)
    : !bus_o.irq && bus_o.irq_oe == $past(irq_req_i)); endproperty
  a_irq: assert property (p_irq) else $error("interrupt pin wrong");
  property p_rel; $rose(active_o) |-> !any_oe && $past(power_reset_n_i, 2) && $past(host_bus_reset_n_i, 2);
  endproperty
  a_rel: assert property (p_rel) else $error("release not synchronised");
endmodule
bind hbrpc_top hbrpc_properties i_props (.clk_sys_i, .reset_i, .power_reset_n_i, .host_bus_reset_n_i,
  .init_phase_i, .irq_req_i, .bus_o, .cfg_o, .ctx_o, .active_o, .card_slot_mode_o);
`default_nettype wire

// ===== verification/hbrpc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hbrpc_top_tb;
  import hbrpc_pkg::*;
  localparam int HOLD = 20;
  typedef struct packed {
    logic [AD_WIDTH-1:0]  ad;
    logic [CBE_WIDTH-1:0] cbe;
    logic                 bad;
    logic                 par;
    logic                 err;
  } hbrpc_row_s;
  localparam hbrpc_row_s ROWS [4] = '{'{32'h0000_0000, 4'h0, 1'h0, 1'h0, 1'h0},
    '{32'hFFFF_FFFF, 4'hF, 1'h1, 1'h0, 1'h1}, '{32'h8000_0001, 4'h7, 1'h0, 1'h1, 1'h0},
    '{32'h1234_5678, 4'hA, 1'h1, 1'h1, 1'h1}};
  logic clk_sys_i = 1'h0, reset_i = 1'h1, strap = 1'h1, irq = 1'h0, cfg_wr = 1'h0, ctx_wr = 1'h0;
  logic pwr_rst = 1'h1, bus_rst = 1'h0, go = 1'h0, bad = 1'h0, active, card, short_o, perr, pwr_n, bus_n, tgt, par;
  logic [CFG_WIDTH-1:0] cfg_wd = 16'h0000, cfg_o;
  logic [CTX_WIDTH-1:0] ctx_wd = 8'h00, ctx_o;
  logic [AD_WIDTH-1:0]  tad = '0, ad;
  logic [CBE_WIDTH-1:0] tcbe = '0, cbe;
  hbrpc_phase_s         init = '0;
  hbrpc_bus_out_s       bus_o;
  int                   n_fail = 0, n_checks = 0;
  wire logic [3:0] oes = {bus_o.ad_oe, bus_o.cbe_oe, bus_o.par_oe, bus_o.irq_oe};
  hbrpc_host_model i_host (.clk_i(clk_sys_i), .pwr_rst_i(pwr_rst), .bus_rst_i(bus_rst), .go_i(go), .ad_i(tad),
    .cbe_i(tcbe), .bad_i(bad), .pwr_n_o(pwr_n), .bus_n_o(bus_n), .tgt_o(tgt), .ad_o(ad), .cbe_o(cbe), .par_o(par));
  hbrpc_top #(.POWER_RESET_CYCLES(HOLD)) i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .power_reset_n_i(pwr_n),
    .host_bus_reset_n_i(bus_n), .card_slot_mode_strap_i(strap), .init_phase_i(init), .tgt_phase_i(tgt), .ad_i(ad),
    .cmd_byte_enable_bus_i(cbe), .bus_parity_line_i(par), .irq_req_i(irq), .cfg_wr_i(cfg_wr), .cfg_wdata_i(cfg_wd),
    .ctx_wr_i(ctx_wr), .ctx_wdata_i(ctx_wd), .bus_o(bus_o), .cfg_o(cfg_o), .ctx_o(ctx_o), .active_o(active),
    .card_slot_mode_o(card), .power_reset_short_o(short_o), .parity_err_o(perr));
  initial forever #20 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wait_active();
    for (int i = 0; i < 10 && active !== 1'h1; i++) cyc(1);
  endtask
  task automatic power_up(input logic s);
    strap = s;
    pwr_rst = 1'h1;
    cyc(HOLD + 5);
    chk({active, oes, cfg_o, ctx_o}, '0);
    pwr_rst = 1'h0;
    wait_active();
    chk({active, card, short_o}, {1'h1, !s, 1'h0});
  endtask
  task automatic irq_test(input logic c);
    for (int v = 0; v < 2; v++)
    begin
      irq = v[0];
      cyc(1);
      chk({bus_o.irq_oe, bus_o.irq}, c ? {1'h1, !v[0]} : {v[0], 1'h0});
    end
  endtask
  // ==========================================================
  // Watchdog and main sequence
  // ==========================================================
  initial
  begin
    #100_000;
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    cyc(20);
    reset_i = 1'h0;
    power_up(1'h1);
    foreach (ROWS[i])
    begin
      init = '{1'h1, ROWS[i].ad, ROWS[i].cbe};
      tad = ROWS[i].ad;
      tcbe = ROWS[i].cbe;
      bad = ROWS[i].bad;
      go = 1'h1;
      cyc(1);
      init = '0;
      go = 1'h0;
      chk({oes[3:2], bus_o.ad, bus_o.cbe}, {2'h3, ROWS[i].ad, ROWS[i].cbe});
      cyc(1);
      chk({oes[1], bus_o.par}, {1'h1, ROWS[i].par});
      cyc(1);
      chk(perr, ROWS[i].err);
    end
    irq_test(1'h0);
    cfg_wd = 16'hA5C3;
    ctx_wd = 8'h5A;
    cfg_wr = 1'h1;
    ctx_wr = 1'h1;
    cyc(1);
    cfg_wr = 1'h0;
    ctx_wr = 1'h0;
    chk({cfg_o, ctx_o}, {16'hA5C3, 8'h5A});
    irq = 1'h1;
    bus_rst = 1'h1;
    cyc(6);
    chk({active, oes}, '0);
    chk({cfg_o, ctx_o}, {CFG_RESET, 8'h5A});
    bus_rst = 1'h0;
    wait_active();
    chk({active, oes, ctx_o}, {1'h1, 4'h0, 8'h5A});
    cyc(1);
    chk(oes, 4'h1);
    power_up(1'h0);
    irq_test(1'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire
